/* File: core/csw_timers.v */
`timescale 1ns/100ps
`default_nettype none
`include "csw_map.vh"

// What this block does
// - timer or sync pulses high-side output periodically
// - wake level change between samples flags event
// - wake event: interrupt low or power regulator
// - initial level held before sense starts
// - nonzero on-time starts sense immediately
// - on-time longer than period flags failure
// - sleep without valid sense source or other wake source: restart
// - wake sampled once at on-phase end
// - sense event sets per-input wake flag
// - level status updated from samples while sensing, else follows pin
// - event raised even if flag set
// - fail-safe: output off, static sensing
// - fault disables affected high-side output
// - stop interrupts, sleep wakes via restart
// - uncleared flags on sleep: immediate restart
// - cyclic wake interrupts or wakes sleep
// - cyclic wake enabled except 000,110,111
// - wake interrupt each on-start except first
// - two timers, mapped per output
// - config only in normal, outputs off restart
module csw_timers #(
	parameter NUM_HS   = 3,
	parameter NUM_WK   = 4,
	parameter TICK_CYC = `CSW_TICK_NS / `CSW_CLK_NS
)(
	input  wire                ref_clk,
	input  wire                reset,
	input  wire                clkEn,
	input  wire                psel,
	input  wire                penable,
	input  wire                pwrite,
	input  wire [11:0]         paddr,
	input  wire [31:0]         pwdata,
	output wire                pready,
	output reg  [31:0]         prdata,
	output wire                pslverr,
	input  wire [2:0]          devMode,
	input  wire                sleepReq,
	input  wire                otherWakeSrc,
	input  wire [NUM_HS-1:0]   hsFault,
	input  wire [NUM_WK-1:0]   wakeInput,
	input  wire                extSyncInput,
	output reg  [NUM_HS-1:0]   highSideOutput,
	output reg                 interruptOutN,
	output reg                 mainRegulatorOn,
	output reg                 restartReq,
	output reg                 resetOutN
);

	// ---------------------------------------------------------------
	// helpers
	// ---------------------------------------------------------------
	// on/period code to ticks: 0.1,0.3,1,10,20,.. ms scaled by tick of 0.1 ms
	function [15:0] onTicks;
		input [2:0] c;
		begin
			case (c)
				3'd1:    onTicks = 16'd1;
				3'd2:    onTicks = 16'd3;
				3'd3:    onTicks = 16'd10;
				3'd4:    onTicks = 16'd100;
				3'd5:    onTicks = 16'd200;
				default: onTicks = 16'd0;
			endcase
		end
	endfunction

	function [15:0] perTicks;
		input [2:0] c;
		begin
			case (c)
				3'd0:    perTicks = 16'd100;
				3'd1:    perTicks = 16'd200;
				3'd2:    perTicks = 16'd500;
				3'd3:    perTicks = 16'd1000;
				3'd4:    perTicks = 16'd2000;
				3'd5:    perTicks = 16'd5000;
				3'd6:    perTicks = 16'd10000;
				default: perTicks = 16'd20000;
			endcase
		end
	endfunction

	function cwEnabled;
		input [2:0] c;
		begin
			cwEnabled = (c != `CSW_ON_OFF) && (c != `CSW_ON_X6) && (c != `CSW_ON_X7);
		end
	endfunction

	// ---------------------------------------------------------------
	// pin synchronisers
	// ---------------------------------------------------------------
	reg  [NUM_WK-1:0] wkMeta_q;
	reg  [NUM_WK-1:0] wkSync_q;
	reg               syncMeta_q;
	reg               syncSync_q;
	reg               syncPrev_q;

	// two stages before any logic sees the pins
	always @(posedge ref_clk)
	begin
		if (reset)
		begin
			wkMeta_q   <= {NUM_WK{1'b0}};
			wkSync_q   <= {NUM_WK{1'b0}};
			syncMeta_q <= 1'b0;
			syncSync_q <= 1'b0;
			syncPrev_q <= 1'b0;
		end
		else if (clkEn)
		begin
			wkMeta_q   <= wakeInput;
			wkSync_q   <= wkMeta_q;
			syncMeta_q <= extSyncInput;
			syncSync_q <= syncMeta_q;
			syncPrev_q <= syncSync_q;
		end
	end

	// ---------------------------------------------------------------
	// registers
	// ---------------------------------------------------------------
	reg  [6:0]          timerCfg_q [0:1];
	reg  [4*NUM_HS-1:0] hsCtrl_q;
	reg  [NUM_WK-1:0]   wkSel_q;
	reg  [NUM_WK-1:0]   wkFlag_q;
	reg  [NUM_WK-1:0]   wkLvl_q;
	reg                 cmdFail_q;
	reg                 cwFlag_q;

	wire accessEn  = psel & penable & clkEn;
	wire wrEn      = accessEn & pwrite;
	wire isNormal  = (devMode == `CSW_MODE_NORMAL);
	wire isStop    = (devMode == `CSW_MODE_STOP);
	wire isSleep   = (devMode == `CSW_MODE_SLEEP);
	wire isFail    = (devMode == `CSW_MODE_FAIL);
	wire isRestart = (devMode == `CSW_MODE_RESTART);
	wire offHit    = (paddr == `CSW_OFF_TIMER0) | (paddr == `CSW_OFF_TIMER1) |
	                 (paddr == `CSW_OFF_HSCTRL) | (paddr == `CSW_OFF_WKCFG) |
	                 (paddr == `CSW_OFF_WKSTAT) | (paddr == `CSW_OFF_WKLVL) |
	                 (paddr == `CSW_OFF_STATUS);

	assign pready  = 1'b1;
	assign pslverr = psel & penable & ~offHit;

	// ---------------------------------------------------------------
	// timers
	// ---------------------------------------------------------------
	reg  [15:0] tickCnt_q;
	wire        tick = (tickCnt_q == TICK_CYC[15:0] - 16'd1);
	reg  [15:0] phase_q [0:1];
	reg  [1:0]  onPh_q;
	reg  [1:0]  first_q;
	reg  [1:0]  onEnd;
	reg  [1:0]  onStart;
	integer     t;
	integer     u;

	// free time base; a timer's phase restarts only when its on-time code is 000 or in fail/restart
	always @(posedge ref_clk)
	begin
		if (reset)
			tickCnt_q <= 16'h0000;
		else if (clkEn)
			tickCnt_q <= tick ? 16'h0000 : tickCnt_q + 16'd1;
	end

	// on-phase occupies start of each period
	always @(posedge ref_clk)
	begin
		if (reset)
		begin
			for (t = 0; t < 2; t = t + 1)
				phase_q[t] <= 16'h0000;
			onPh_q  <= 2'b00;
			first_q <= 2'b11;
		end
		else if (clkEn)
		begin
			for (t = 0; t < 2; t = t + 1)
			begin
				if (timerCfg_q[t][2:0] == `CSW_ON_OFF || isRestart || isFail)
				begin
					phase_q[t] <= 16'h0000;
					onPh_q[t]  <= 1'b0;
					first_q[t] <= 1'b1;
				end
				else if (first_q[t])
				begin
					// launch opens the on-phase at once; this start never interrupts
					phase_q[t] <= 16'h0000;
					onPh_q[t]  <= 1'b1;
					first_q[t] <= 1'b0;
				end
				else if (tick)
				begin
					phase_q[t] <= (phase_q[t] + 16'd1 >= perTicks(timerCfg_q[t][6:4])) ?
					              16'h0000 : phase_q[t] + 16'd1;
					onPh_q[t]  <= (phase_q[t] + 16'd1 < onTicks(timerCfg_q[t][2:0])) ||
					              (phase_q[t] + 16'd1 >= perTicks(timerCfg_q[t][6:4]));
				end
			end
		end
	end

	// phase edges: start of on-time and end of on-time
	always @*
	begin
		for (u = 0; u < 2; u = u + 1)
		begin
			onEnd[u]   = tick & onPh_q[u] & (phase_q[u] + 16'd1 == onTicks(timerCfg_q[u][2:0]));
			onStart[u] = tick & (phase_q[u] + 16'd1 >= perTicks(timerCfg_q[u][6:4]))
			             & (timerCfg_q[u][2:0] != `CSW_ON_OFF);
		end
	end

	// ---------------------------------------------------------------
	// high-side outputs and sample points
	// ---------------------------------------------------------------
	reg  [NUM_HS-1:0] hsOn;
	reg               sampleNow;
	reg               senseActive;
	reg  [1:0]        tmrMapped;
	integer           h;

	// a timer mapped to an output senses; only unmapped timers wake
	always @*
	begin
		hsOn        = {NUM_HS{1'b0}};
		tmrMapped   = 2'b00;
		sampleNow   = 1'b0;
		senseActive = 1'b0;
		for (h = 0; h < NUM_HS; h = h + 1)
		begin
			case (hsCtrl_q[4*h +: 2])
				`CSW_SRC_T0:
				begin
					hsOn[h]     = (timerCfg_q[0][2:0] != `CSW_ON_OFF) ? onPh_q[0] :
					              hsCtrl_q[4*h+`CSW_HS_INIT_BIT];
					sampleNow   = sampleNow | onEnd[0];
					tmrMapped[0] = 1'b1;
					senseActive = senseActive | (timerCfg_q[0][2:0] != `CSW_ON_OFF);
				end
				`CSW_SRC_T1:
				begin
					hsOn[h]     = (timerCfg_q[1][2:0] != `CSW_ON_OFF) ? onPh_q[1] :
					              hsCtrl_q[4*h+`CSW_HS_INIT_BIT];
					sampleNow   = sampleNow | onEnd[1];
					tmrMapped[1] = 1'b1;
					senseActive = senseActive | (timerCfg_q[1][2:0] != `CSW_ON_OFF);
				end
				`CSW_SRC_SYNC:
				begin
					hsOn[h]     = syncSync_q;
					sampleNow   = sampleNow | (syncPrev_q & ~syncSync_q);
					senseActive = 1'b1;
				end
				default:
					hsOn[h] = hsCtrl_q[4*h+`CSW_HS_INIT_BIT];
			endcase
		end
	end

	// faulted or mode-disabled outputs drop at once
	always @(posedge ref_clk)
	begin
		if (reset)
			highSideOutput <= {NUM_HS{1'b0}};
		else if (clkEn)
			highSideOutput <= (isFail || isRestart) ? {NUM_HS{1'b0}} :
			                  hsOn & ~hsFault;
	end

	// ---------------------------------------------------------------
	// wake detection
	// ---------------------------------------------------------------
	wire [NUM_WK-1:0] wkChange = (wkSync_q ^ wkLvl_q) & wkSel_q;
	wire              senseMode = senseActive & ~isFail;
	// static sensing in fail-safe may itself raise an event
	wire [NUM_WK-1:0] wkEvt = (senseMode & sampleNow) ? wkChange :
	                          isFail ? wkChange : {NUM_WK{1'b0}};
	wire              cwEvt = (onStart[0] & ~first_q[0] & ~tmrMapped[0] &
	                           cwEnabled(timerCfg_q[0][2:0])) |
	                          (onStart[1] & ~first_q[1] & ~tmrMapped[1] &
	                           cwEnabled(timerCfg_q[1][2:0]));
	wire              anyEvt = (|wkEvt) | cwEvt;

	// level status follows samples only while sensing
	always @(posedge ref_clk)
	begin
		if (reset)
			wkLvl_q <= {NUM_WK{1'b0}};
		else if (clkEn)
		begin
			if (!senseMode || (senseMode & sampleNow))
				wkLvl_q <= wkSync_q;
		end
	end

	// ---------------------------------------------------------------
	// register writes; config writable only in normal mode, timers and mapping cleared in fail/restart
	// ---------------------------------------------------------------
	always @(posedge ref_clk)
	begin
		if (reset)
		begin
			timerCfg_q[0] <= 7'h00;
			timerCfg_q[1] <= 7'h00;
			hsCtrl_q      <= {4*NUM_HS{1'b0}};
			wkSel_q       <= {NUM_WK{1'b0}};
			wkFlag_q      <= {NUM_WK{1'b0}};
			cwFlag_q      <= 1'b0;
			cmdFail_q     <= 1'b0;
		end
		else if (clkEn)
		begin
			if (wrEn && isNormal && paddr == `CSW_OFF_TIMER0)
				timerCfg_q[0] <= pwdata[6:0];
			if (wrEn && isNormal && paddr == `CSW_OFF_TIMER1)
				timerCfg_q[1] <= pwdata[6:0];
			if (wrEn && isNormal && paddr == `CSW_OFF_HSCTRL)
				hsCtrl_q <= pwdata[4*NUM_HS-1:0];
			if (wrEn && isNormal && paddr == `CSW_OFF_WKCFG)
				wkSel_q <= pwdata[NUM_WK-1:0];
			// fail or restart drops mapping and timers; host must set up again
			if (isFail || isRestart)
			begin
				timerCfg_q[0] <= 7'h00;
				timerCfg_q[1] <= 7'h00;
				hsCtrl_q      <= {4*NUM_HS{1'b0}};
			end
			// set wins over write-one-to-clear
			wkFlag_q <= (wkFlag_q & ~((wrEn && paddr == `CSW_OFF_WKSTAT) ?
			            pwdata[NUM_WK-1:0] : {NUM_WK{1'b0}})) | wkEvt;
			cwFlag_q <= (cwFlag_q & ~(wrEn && paddr == `CSW_OFF_WKSTAT && pwdata[8])) | cwEvt;
			if (wrEn && paddr == `CSW_OFF_STATUS && pwdata[0])
				cmdFail_q <= 1'b0;
			if (wrEn && isNormal && (paddr == `CSW_OFF_TIMER0 || paddr == `CSW_OFF_TIMER1) &&
			    onTicks(pwdata[2:0]) > perTicks(pwdata[6:4]))
				cmdFail_q <= 1'b1;
			if (sleepReq && ((!senseActive && !otherWakeSrc) || (|wkFlag_q) || cwFlag_q))
				cmdFail_q <= 1'b1;
		end
	end

	// ---------------------------------------------------------------
	// mode reactions: interrupt, regulator, restart
	// ---------------------------------------------------------------
	always @(posedge ref_clk)
	begin
		if (reset)
		begin
			interruptOutN   <= 1'b1;
			mainRegulatorOn <= 1'b1;
			restartReq      <= 1'b0;
			resetOutN       <= 1'b1;
		end
		else if (clkEn)
		begin
			// one-cycle low pulse per event in normal or stop
			interruptOutN   <= ~(anyEvt & (isNormal | isStop));
			// sleep wake or bad sleep entry goes via restart
			restartReq      <= (anyEvt & isSleep) |
			                   (sleepReq & ((!senseActive && !otherWakeSrc) ||
			                   (|wkFlag_q) || cwFlag_q));
			mainRegulatorOn <= isSleep ? (anyEvt | ~mainRegulatorOn ? anyEvt : 1'b0) : 1'b1;
			resetOutN       <= ~(isRestart | (sleepReq & ((|wkFlag_q) | cwFlag_q)));
		end
	end

	// ---------------------------------------------------------------
	// read data
	// ---------------------------------------------------------------
	always @(posedge ref_clk)
	begin
		if (reset)
			prdata <= `CSW_RST_ZERO;
		else if (clkEn && psel && !penable && !pwrite)
		begin
			case (paddr)
				`CSW_OFF_TIMER0: prdata <= {25'd0, timerCfg_q[0]};
				`CSW_OFF_TIMER1: prdata <= {25'd0, timerCfg_q[1]};
				`CSW_OFF_HSCTRL: prdata <= {{(32-4*NUM_HS){1'b0}}, hsCtrl_q};
				`CSW_OFF_WKCFG:  prdata <= {{(32-NUM_WK){1'b0}}, wkSel_q};
				`CSW_OFF_WKSTAT: prdata <= {23'd0, cwFlag_q, {(8-NUM_WK){1'b0}}, wkFlag_q};
				`CSW_OFF_WKLVL:  prdata <= {{(32-NUM_WK){1'b0}}, wkLvl_q};
				`CSW_OFF_STATUS: prdata <= {30'd0, onPh_q[0] | onPh_q[1], cmdFail_q};
				default:         prdata <= `CSW_RST_ZERO;
			endcase
		end
	end

endmodule // csw_timers
`default_nettype wire

/* File: core/csw_map.vh */
`ifndef CSW_MAP_VH
`define CSW_MAP_VH
// ---------------------------------------------------------------
// register byte offsets
// ---------------------------------------------------------------
`define CSW_OFF_TIMER0   12'h000
`define CSW_OFF_TIMER1   12'h004
`define CSW_OFF_HSCTRL   12'h008
`define CSW_OFF_WKCFG    12'h00C
`define CSW_OFF_WKSTAT   12'h010
`define CSW_OFF_WKLVL    12'h014
`define CSW_OFF_STATUS   12'h018
// ---------------------------------------------------------------
// timer register fields: on-time code [2:0], period code [6:4]
// ---------------------------------------------------------------
`define CSW_ON_LSB       0
`define CSW_PER_LSB      4
`define CSW_ON_OFF       3'b000
`define CSW_ON_X6        3'b110
`define CSW_ON_X7        3'b111
// ---------------------------------------------------------------
// high-side control fields (per output, 4 bits): [1:0] source, [2] initial high
// ---------------------------------------------------------------
`define CSW_SRC_OFF      2'b00
`define CSW_SRC_T0       2'b01
`define CSW_SRC_T1       2'b10
`define CSW_SRC_SYNC     2'b11
`define CSW_HS_INIT_BIT  2
// ---------------------------------------------------------------
// device modes
// ---------------------------------------------------------------
`define CSW_MODE_NORMAL  3'd0
`define CSW_MODE_STOP    3'd1
`define CSW_MODE_SLEEP   3'd2
`define CSW_MODE_RESTART 3'd3
`define CSW_MODE_FAIL    3'd4
// ---------------------------------------------------------------
// timing: one time base tick, in ns, and reset values
// ---------------------------------------------------------------
`define CSW_TICK_NS      100000
`define CSW_CLK_NS       8
`define CSW_RST_ZERO     32'h0000_0000
`endif

/* File: sim/csw_wake_switch.sv */
`timescale 1ns/100ps
`default_nettype none
// ---------------------------------------------
// wake contact fed from a high-side output
// ---------------------------------------------
module csw_wake_switch (
	input  wire logic hsOn,
	input  wire logic closed,
	output var  logic wakeLevel
);
	// contact to ground with a pull-up fed by the output;
	// unpowered, the line is pulled low, so only on-phases show the contact
	always_comb
	begin
		wakeLevel = hsOn && !closed;
	end
endmodule // csw_wake_switch
`default_nettype wire

/* File: sim/csw_timers_asserts.sv */
`timescale 1ns/100ps
`default_nettype none
// ---------------------------------------------
// port checks for the sense and wake timers
// ---------------------------------------------
module csw_timers_asserts #(
	parameter NUM_HS = 3
)(
	input wire logic              ref_clk,
	input wire logic              reset,
	input wire logic              psel,
	input wire logic              penable,
	input wire logic [11:0]       paddr,
	input wire logic              pslverr,
	input wire logic [2:0]        devMode,
	input wire logic [NUM_HS-1:0] hsFault,
	input wire logic [NUM_HS-1:0] highSideOutput,
	input wire logic              interruptOutN,
	input wire logic              restartReq,
	input wire logic              resetOutN
);
	default clocking @(posedge ref_clk); endclocking
	default disable iff (reset);
	AST_UNMAPPED: assert property (psel && penable && paddr == 12'h01C |-> pslverr)
		else $error("unmapped access without slave error");
	AST_FAULT_OFF: assert property (hsFault[0] ##1 hsFault[0] |-> !highSideOutput[0])
		else $error("faulted output still on");
	AST_FAIL_OFF: assert property (devMode == 3'd4 ##1 devMode == 3'd4 |-> highSideOutput == '0)
		else $error("output on in fail-safe");
	AST_RESTART_OFF: assert property (devMode == 3'd3 ##1 devMode == 3'd3 |-> highSideOutput == '0)
		else $error("output on in restart");
	AST_RESET_OUT_N_LOW: assert property (devMode == 3'd3 ##1 devMode == 3'd3 |-> !resetOutN)
		else $error("reset output high in restart");
	AST_INT_PULSE: assert property ($fell(interruptOutN) |=> interruptOutN)
		else $error("interrupt low longer than one cycle");
	AST_INT_MODE: assert property (!interruptOutN |-> $past(devMode) inside {3'd0, 3'd1})
		else $error("interrupt outside normal or stop");
	AST_RESTART_PULSE: assert property (restartReq |=> !restartReq)
		else $error("restart request longer than one cycle");
endmodule // csw_timers_asserts
bind csw_timers csw_timers_asserts #(.NUM_HS(NUM_HS)) u_chk (.ref_clk(ref_clk), .reset(reset),
	.psel(psel), .penable(penable), .paddr(paddr), .pslverr(pslverr), .devMode(devMode),
	.hsFault(hsFault), .highSideOutput(highSideOutput), .interruptOutN(interruptOutN),
	.restartReq(restartReq), .resetOutN(resetOutN));
`default_nettype wire

/* File: sim/csw_timers_tb.sv */
`timescale 1ns/100ps
`default_nettype none
`include "csw_map.vh"
// ---------------------------------------------
// bench for the sense and wake timers
// ---------------------------------------------
module csw_timers_tb;
	localparam int PERIOD = 400; // 10 ms at four cycles a tick
	logic        ref_clk, reset, psel, penable, pwrite, sleepReq, closed, slvErr;
	logic        otherWake, syncIn, regPrev;
	logic [11:0] paddr;
	logic [31:0] pwdata, rd;
	logic [2:0]  devMode, hsFault;
	wire         wakeLevel, pready, pslverr, interruptOutN, restartReq, resetOutN;
	wire         regOn;
	wire  [31:0] prdata;
	wire  [2:0]  highSideOutput;
	int          errTotal, numChecks, intCount, rstCount, regCount;

	csw_timers #(.TICK_CYC(4)) dut (.ref_clk(ref_clk), .reset(reset), .clkEn(1'b1),
		.psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
		.pready(pready), .prdata(prdata), .pslverr(pslverr), .devMode(devMode),
		.sleepReq(sleepReq), .otherWakeSrc(otherWake), .hsFault(hsFault),
		.wakeInput({3'b000, wakeLevel}), .extSyncInput(syncIn),
		.highSideOutput(highSideOutput), .interruptOutN(interruptOutN),
		.mainRegulatorOn(regOn), .restartReq(restartReq), .resetOutN(resetOutN));
	csw_wake_switch sw (.hsOn(highSideOutput[0]), .closed(closed), .wakeLevel(wakeLevel));

	// clock
	initial
	begin
		ref_clk = 1'b0;
		forever #4 ref_clk = ~ref_clk;
	end

	// count interrupt and restart pulses
	always @(posedge ref_clk)
	begin
		if (interruptOutN === 1'b0) intCount++;
		if (restartReq === 1'b1) rstCount++;
		if (regOn === 1'b1 && regPrev === 1'b0) regCount++;
		regPrev = regOn;
	end

	task automatic check(input string n, input logic [31:0] seen, input logic [31:0] exp);
		numChecks++;
		if (seen !== exp)
		begin
			errTotal++;
			$display("[ERR] %s expected %h seen %h", n, exp, seen);
		end
	endtask

	// one apb transfer; first edge wait keeps back-to-back calls apart
	task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] wd);
		@(posedge ref_clk);
		psel    <= 1'b1;
		penable <= 1'b0;
		pwrite  <= wr;
		paddr   <= a;
		pwdata  <= wd;
		@(posedge ref_clk);
		penable <= 1'b1;
		do @(posedge ref_clk); while (pready !== 1'b1);
		rd = prdata;
		slvErr = pslverr;
		psel    <= 1'b0;
		penable <= 1'b0;
	endtask

	task automatic wr(input logic [11:0] a, input logic [31:0] d);
		apb(1'b1, a, d);
	endtask

	task automatic rdChk(input string n, input logic [11:0] a, input logic [31:0] m,
		input logic [31:0] e);
		apb(1'b0, a, 32'h0000_0000);
		check(n, rd & m, e);
	endtask

	task automatic idle(input int n);
		repeat (n) @(posedge ref_clk);
	endtask

	// bounded wait for a level on output 0
	task automatic waitHs(input logic v);
		repeat (PERIOD + 20) if (highSideOutput[0] !== v) @(posedge ref_clk);
		check("hs phase", highSideOutput[0], v);
	endtask

	task automatic sleepTry(input int e);
		rstCount = 0;
		@(posedge ref_clk);
		sleepReq <= 1'b1;
		@(posedge ref_clk);
		sleepReq <= 1'b0;
		idle(8);
		check("restart pulses", rstCount, e);
	endtask

	task automatic testDone;
		if (errTotal == 0 && numChecks > 0) $display("Test passed");
		else $display("Test failed");
		$finish;
	endtask

	// watchdog
	initial
	begin
		idle(30000);
		errTotal++;
		testDone();
	end

	// main sequence
	initial
	begin
		{reset, psel, penable, pwrite, sleepReq, closed} = 6'b10_0000;
		{paddr, pwdata, devMode, hsFault} = '0;
		{otherWake, syncIn} = 2'b00;
		idle(3);
		reset <= 1'b0;
		rdChk("status", `CSW_OFF_STATUS, 32'hFFFF_FFFF, 32'h0000_0000);
		rdChk("unmapped", 12'h01C, 32'hFFFF_FFFF, 32'h0000_0000);
		check("slverr", slvErr, 32'h0000_0001);
		wr(`CSW_OFF_TIMER1, 32'h0000_0003);
		rdChk("cmd ok", `CSW_OFF_STATUS, 32'h0000_0001, 32'h0000_0000);
		wr(`CSW_OFF_TIMER1, 32'h0000_0005);
		rdChk("cmd fail", `CSW_OFF_STATUS, 32'h0000_0001, 32'h0000_0001);
		wr(`CSW_OFF_TIMER1, 32'h0000_0000);
		wr(`CSW_OFF_STATUS, 32'h0000_0001);
		// sense setup in host order
		wr(`CSW_OFF_HSCTRL, 32'h0000_0000);
		wr(`CSW_OFF_HSCTRL, 32'h0000_0001);
		wr(`CSW_OFF_WKCFG, 32'h0000_0001);
		check("hs idle", highSideOutput, 3'b000);
		wr(`CSW_OFF_TIMER0, 32'h0000_0002);
		idle(3);
		check("hs on", highSideOutput, 3'b001);
		idle(1000);
		wr(`CSW_OFF_WKSTAT, 32'h0000_01FF);
		intCount = 0;
		waitHs(1'b1);
		waitHs(1'b0);
		closed <= 1'b1;
		rdChk("level held", `CSW_OFF_WKLVL, 32'h0000_0001, 32'h0000_0001);
		idle(PERIOD);
		rdChk("level sampled", `CSW_OFF_WKLVL, 32'h0000_0001, 32'h0000_0000);
		check("sense int", intCount, 1);
		rdChk("wake flag", `CSW_OFF_WKSTAT, 32'h0000_0001, 32'h0000_0001);
		closed <= 1'b0;
		idle(PERIOD);
		check("repeat int", intCount, 2);
		sleepTry(1);
		wr(`CSW_OFF_WKSTAT, 32'h0000_01FF);
		sleepTry(0);
		// stop mode: config frozen, sense still interrupts
		intCount = 0;
		devMode <= `CSW_MODE_STOP;
		closed <= 1'b1;
		wr(`CSW_OFF_HSCTRL, 32'h0000_0000);
		idle(PERIOD + 20);
		check("stop int", intCount, 1);
		rdChk("hs frozen", `CSW_OFF_HSCTRL, 32'h0000_0FFF, 32'h0000_0001);
		devMode <= `CSW_MODE_NORMAL;
		hsFault <= 3'b001;
		idle(PERIOD + 20);
		check("fault off", highSideOutput, 3'b000);
		hsFault <= 3'b000;
		devMode <= `CSW_MODE_FAIL;
		idle(4);
		check("fail off", highSideOutput, 3'b000);
		devMode <= `CSW_MODE_RESTART;
		idle(4);
		check("reset out", resetOutN, 1'b0);
		devMode <= `CSW_MODE_NORMAL;
		rdChk("hs cleared", `CSW_OFF_HSCTRL, 32'h0000_0FFF, 32'h0000_0000);
		rdChk("timer cleared", `CSW_OFF_TIMER0, 32'h0000_007F, 32'h0000_0000);
		// sync pin drives output 0 through its two stages
		wr(`CSW_OFF_HSCTRL, 32'h0000_0003);
		syncIn <= 1'b1;
		idle(4);
		check("sync on", highSideOutput, 3'b001);
		syncIn <= 1'b0;
		idle(4);
		check("sync off", highSideOutput, 3'b000);
		wr(`CSW_OFF_HSCTRL, 32'h0000_0000);
		wr(`CSW_OFF_WKSTAT, 32'h0000_01FF);
		sleepTry(1);
		otherWake <= 1'b1;
		sleepTry(0);
		otherWake <= 1'b0;
		// cyclic wake over every on-time code
		for (int c = 0; c < 8; c++)
		begin
			intCount = 0;
			wr(`CSW_OFF_TIMER1, 32'(c));
			idle(PERIOD + 200);
			check("wake ints", intCount, (c == 0 || c > 5) ? 0 : 1);
			rdChk("wake bit", `CSW_OFF_WKSTAT, 32'h0000_0100,
				(c == 0 || c > 5) ? 32'h0000_0000 : 32'h0000_0100);
			wr(`CSW_OFF_TIMER1, 32'h0000_0000);
			wr(`CSW_OFF_WKSTAT, 32'h0000_01FF);
		end
		// cyclic wake in sleep: one regulator pulse and restart, no interrupt
		wr(`CSW_OFF_TIMER1, 32'h0000_0001);
		devMode <= `CSW_MODE_SLEEP;
		intCount = 0;
		rstCount = 0;
		regCount = 0;
		idle(PERIOD + 200);
		check("sleep wake", rstCount, 1);
		check("sleep int", intCount, 0);
		check("regulator", regCount, 1);
		devMode <= `CSW_MODE_NORMAL;
		testDone();
	end
endmodule // csw_timers_tb
`default_nettype wire
